/* File: rtl/sltpg_top.sv */
// Purpose: Link-side test pattern generator with byte register port
// Assumes: i_step marks one frame, symbol or octet slot of the datapath
// Notes: Narrow words are low-aligned in o_tp.data, upper bits zero
// How it works
// - Control bits 3:0 pick the pattern; 0000 is off and the reset value
// - Control bits 5:4 pick the insertion point
// - Insertion points: sample input, 10-bit symbol, 8-bit scrambler octet
// - Point 00 gives 16-bit sample words
// - Code 0011: PN31, x^31+x^28+1, seed 0x0003AFFF
// - Code 0100: PN23, x^23+x^18+1, seed 0x003AFF
// - Codes 0101/0110/0111: PN15, PN9, PN7 with their seeds
// - Code 1000: ramp wrapping at the insertion point width
// - Four user words from byte registers 0x551 to 0x558
// - Code 1110: user words one to four, repeating forever
// - Code 1111: user words one to four once, then zeros
// - One pattern word per frame, shared by every sample
// - Sample point uses all sixteen user word bits
// - Point 01 truncates check, toggle and user words to their upper ten bits
// - Point 10 gives one octet per pattern step
`timescale 1ns/1ps
`include "sltpg_cfg.svh"
module sltpg_top (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [11:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	input wire logic i_step,
	input wire logic [15:0] i_norm_data,
	output sltpg_pkg::sltpg_out_t o_tp
);
	import sltpg_pkg::*;

	logic [7:0] ctrl, next_ctrl;
	logic [7:0] user [0:7];
	logic [7:0] next_user [0:7];
	logic [7:0] next_rdata;
	logic [30:0] lfsr, next_lfsr;
	logic chk, next_chk;
	logic [15:0] ramp, next_ramp;
	logic [1:0] uidx, next_uidx;
	logic udone, next_udone;
	sltpg_out_t next_tp;
	logic [3:0] code;
	sltpg_point_t point;
	logic active, reinit, soft_rst;
	logic [4:0] width, pn_len, pn_tap;
	logic [30:0] pn_seed;
	logic [15:0] cur, uword;
	logic [46:0] pn_res;

	// Shift a sequence by w bits; register bit 0 leaves first and new
	// bits enter at the top of the sequence length
	function automatic logic [46:0] pn_run(input logic [30:0] s,
		input logic [4:0] len, input logic [4:0] tap, input logic [4:0] w);
		logic [30:0] st;
		logic [15:0] b;
		logic fb;
		st = s;
		b = 16'h0000;
		fb = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (i < int'(w)) begin
				fb = st[0] ^ st[len - tap];
				b = {b[14:0], st[0]};
				st = (st >> 1) | (31'(fb) << (len - 5'h01));
			end
		end
		return {st, b};
	endfunction

	// Field decode and mode qualification
	assign code = ctrl[`SLTPG_CODE_MSB:`SLTPG_CODE_LSB];
	assign point = sltpg_point_t'(ctrl[`SLTPG_POINT_MSB:`SLTPG_POINT_LSB]);
	assign soft_rst = i_reg_wr && i_reg_addr == `SLTPG_ADDR_SOFT_RST &&
		i_reg_wdata == `SLTPG_SOFT_RST_VAL;
	assign reinit = soft_rst || (i_reg_wr && (i_reg_addr == `SLTPG_ADDR_CTRL));
	always_comb begin
		case (code)
			`SLTPG_CODE_CHECK, `SLTPG_CODE_TOGGLE, `SLTPG_CODE_PN31,
			`SLTPG_CODE_PN23, `SLTPG_CODE_PN15, `SLTPG_CODE_PN9,
			`SLTPG_CODE_PN7, `SLTPG_CODE_RAMP, `SLTPG_CODE_REPEAT,
			`SLTPG_CODE_SINGLE: active = 1'b1;
			default: active = 1'b0;
		endcase
	end

	// Word width per insertion point
	always_comb begin
		case (point)
			SLTPG_PT_SYMBOL: width = `SLTPG_W_SYMBOL;
			SLTPG_PT_OCTET: width = `SLTPG_W_OCTET;
			default: width = `SLTPG_W_SAMPLE;
		endcase
	end

	// Sequence selection for the running code
	always_comb begin
		case (code)
			`SLTPG_CODE_PN31: begin
				pn_len = `SLTPG_PN31_LEN;
				pn_tap = `SLTPG_PN31_TAP;
			end
			`SLTPG_CODE_PN23: begin
				pn_len = `SLTPG_PN23_LEN;
				pn_tap = `SLTPG_PN23_TAP;
			end
			`SLTPG_CODE_PN15: begin
				pn_len = `SLTPG_PN15_LEN;
				pn_tap = `SLTPG_PN15_TAP;
			end
			`SLTPG_CODE_PN7: begin
				pn_len = `SLTPG_PN7_LEN;
				pn_tap = `SLTPG_PN7_TAP;
			end
			default: begin
				pn_len = `SLTPG_PN9_LEN;
				pn_tap = `SLTPG_PN9_TAP;
			end
		endcase
	end

	// Seed of the code being written, so a restart loads the new sequence
	always_comb begin
		case (next_ctrl[`SLTPG_CODE_MSB:`SLTPG_CODE_LSB])
			`SLTPG_CODE_PN31: pn_seed = `SLTPG_PN31_SEED;
			`SLTPG_CODE_PN23: pn_seed = `SLTPG_PN23_SEED;
			`SLTPG_CODE_PN15: pn_seed = `SLTPG_PN15_SEED;
			`SLTPG_CODE_PN7: pn_seed = `SLTPG_PN7_SEED;
			default: pn_seed = `SLTPG_PN9_SEED;
		endcase
	end
	assign pn_res = pn_run(lfsr, pn_len, pn_tap, width);
	assign uword = udone ? 16'h0000 : {user[{uidx, 1'b1}], user[{uidx, 1'b0}]};

	// Current pattern word, low-aligned at the point width
	always_comb begin
		case (code)
			`SLTPG_CODE_CHECK: cur = (chk ? `SLTPG_CHECK_B : `SLTPG_CHECK_A)
				>> (5'h10 - width);
			`SLTPG_CODE_TOGGLE: cur = (chk ? `SLTPG_ONES : 16'h0000)
				>> (5'h10 - width);
			`SLTPG_CODE_RAMP: cur = ramp & (`SLTPG_ONES >> (5'h10 - width));
			`SLTPG_CODE_REPEAT, `SLTPG_CODE_SINGLE:
				cur = uword >> (5'h10 - width);
			default: cur = pn_res[15:0];
		endcase
	end

	// Register port: writes, soft reset and read data
	always_comb begin
		next_ctrl = ctrl;
		next_user = user;
		next_rdata = 8'h00;
		if (soft_rst) begin
			next_ctrl = `SLTPG_CTRL_RST;
		end else if (i_reg_wr && i_reg_addr == `SLTPG_ADDR_CTRL) begin
			next_ctrl = i_reg_wdata;
		end else if (i_reg_wr && i_reg_addr >= `SLTPG_ADDR_USER_LO &&
			i_reg_addr <= `SLTPG_ADDR_USER_HI) begin
			next_user[3'(i_reg_addr - `SLTPG_ADDR_USER_LO)] = i_reg_wdata;
		end
		if (i_reg_rd && i_reg_addr == `SLTPG_ADDR_CTRL) begin
			next_rdata = ctrl;
		end else if (i_reg_rd && i_reg_addr >= `SLTPG_ADDR_USER_LO &&
			i_reg_addr <= `SLTPG_ADDR_USER_HI) begin
			next_rdata = user[3'(i_reg_addr - `SLTPG_ADDR_USER_LO)];
		end
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl <= `SLTPG_CTRL_RST;
			user <= '{default: 8'h00};
			o_reg_rdata <= 8'h00;
		end else begin
			ctrl <= next_ctrl;
			user <= next_user;
			o_reg_rdata <= next_rdata;
		end
	end

	// Generator state: advances once per step, restarts on control write
	always_comb begin
		next_lfsr = lfsr;
		next_chk = chk;
		next_ramp = ramp;
		next_uidx = uidx;
		next_udone = udone;
		next_tp.active = active;
		next_tp.point = point;
		next_tp.data = o_tp.data;
		if (!active) begin
			next_tp.data = i_norm_data;
		end else if (i_step) begin
			next_tp.data = cur;
			next_lfsr = pn_res[46:16];
			next_chk = !chk;
			next_ramp = ramp + 16'h0001;
			next_uidx = uidx + 2'b01;
			if (code == `SLTPG_CODE_SINGLE && uidx == 2'b11) begin
				next_udone = 1'b1;
			end
		end
		if (reinit) begin
			next_lfsr = pn_seed;
			next_chk = 1'b0;
			next_ramp = 16'h0000;
			next_uidx = 2'b00;
			next_udone = 1'b0;
		end
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			lfsr <= `SLTPG_PN9_SEED;
			chk <= 1'b0;
			ramp <= 16'h0000;
			uidx <= 2'b00;
			udone <= 1'b0;
			o_tp <= '0;
		end else begin
			lfsr <= next_lfsr;
			chk <= next_chk;
			ramp <= next_ramp;
			uidx <= next_uidx;
			udone <= next_udone;
			o_tp <= next_tp;
		end
	end

	// Checks on the generator
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	logic go;
	assign go = active && i_step && !reinit;
	a_off_pass: assert property (!active |=> o_tp.data == $past(i_norm_data))
		else $error("normal data not passed while off");
	a_point_field: assert property (##1 o_tp.point == $past(ctrl[5:4]))
		else $error("insertion point does not follow control");
	a_seed_load: assert property (reinit |=> lfsr == $past(pn_seed))
		else $error("sequence not restarted from its seed");
	a_check_alt: assert property (go && code == `SLTPG_CODE_CHECK &&
		point == SLTPG_PT_SAMPLE |=> o_tp.data == (
		$past(chk) ? `SLTPG_CHECK_B : `SLTPG_CHECK_A))
		else $error("checkerboard word wrong");
	a_ramp_step: assert property (go |=> ramp == $past(ramp) + 16'h0001)
		else $error("ramp did not advance by one");
	a_user_next: assert property (go |=> uidx == $past(uidx) + 2'b01)
		else $error("user word index did not advance");
	a_single_zero: assert property (go && code == `SLTPG_CODE_SINGLE &&
		udone |=> o_tp.data == 16'h0000)
		else $error("single user mode not zero after four words");
	a_sym_trunc: assert property (go && point == SLTPG_PT_SYMBOL
		|=> o_tp.data[15:10] == 6'h00)
		else $error("symbol word wider than ten bits");
	a_oct_trunc: assert property (go && point == SLTPG_PT_OCTET
		|=> o_tp.data[15:8] == 8'h00)
		else $error("octet word wider than eight bits");
	a_frame_hold: assert property (active && !i_step && $past(active)
		|=> $stable(o_tp.data))
		else $error("pattern word changed without a step");
	c_pn9_step: cover property (go && code == `SLTPG_CODE_PN9);
	c_single_done: cover property (go && code == `SLTPG_CODE_SINGLE && udone);
	c_ramp_wrap: cover property (go && ramp == 16'hFFFF);
endmodule

/* File: rtl/sltpg_cfg.svh */
// Purpose: Offsets, field positions, codes, seeds and taps of the generator
// Assumes: Byte-wide register space with 12-bit addresses
// Notes: Included by the generator and by its bench
`ifndef SLTPG_CFG_SVH
`define SLTPG_CFG_SVH
// Register offsets
`define SLTPG_ADDR_SOFT_RST 12'h000
`define SLTPG_ADDR_CTRL 12'h573
`define SLTPG_ADDR_USER_LO 12'h551
`define SLTPG_ADDR_USER_HI 12'h558
`define SLTPG_SOFT_RST_VAL 8'h81
`define SLTPG_CTRL_RST 8'h00
// Control fields
`define SLTPG_CODE_MSB 3
`define SLTPG_CODE_LSB 0
`define SLTPG_POINT_MSB 5
`define SLTPG_POINT_LSB 4
// Pattern codes
`define SLTPG_CODE_OFF 4'h0
`define SLTPG_CODE_CHECK 4'h1
`define SLTPG_CODE_TOGGLE 4'h2
`define SLTPG_CODE_PN31 4'h3
`define SLTPG_CODE_PN23 4'h4
`define SLTPG_CODE_PN15 4'h5
`define SLTPG_CODE_PN9 4'h6
`define SLTPG_CODE_PN7 4'h7
`define SLTPG_CODE_RAMP 4'h8
`define SLTPG_CODE_REPEAT 4'hE
`define SLTPG_CODE_SINGLE 4'hF
// Fixed words
`define SLTPG_CHECK_A 16'h5555
`define SLTPG_CHECK_B 16'hAAAA
`define SLTPG_ONES 16'hFFFF
// Sequence lengths, taps and seeds
`define SLTPG_PN31_LEN 5'h1F
`define SLTPG_PN31_TAP 5'h1C
`define SLTPG_PN31_SEED 31'h0003AFFF
`define SLTPG_PN23_LEN 5'h17
`define SLTPG_PN23_TAP 5'h12
`define SLTPG_PN23_SEED 31'h0000_3AFF
`define SLTPG_PN15_LEN 5'h0F
`define SLTPG_PN15_TAP 5'h0E
`define SLTPG_PN15_SEED 31'h0000_03AF
`define SLTPG_PN9_LEN 5'h09
`define SLTPG_PN9_TAP 5'h05
`define SLTPG_PN9_SEED 31'h0000_0092
`define SLTPG_PN7_LEN 5'h07
`define SLTPG_PN7_TAP 5'h06
`define SLTPG_PN7_SEED 31'h0000_0007
// Word widths per insertion point
`define SLTPG_W_SAMPLE 5'h10
`define SLTPG_W_SYMBOL 5'h0A
`define SLTPG_W_OCTET 5'h08
`endif

/* File: rtl/sltpg_pkg.sv */
// Purpose: Types shared by the test pattern generator
// Assumes: Nothing beyond the cfg header
// Notes: Output word carried low-aligned at narrow insertion points
package sltpg_pkg;
	// Where the pattern enters the datapath
	typedef enum logic [1:0] {
		SLTPG_PT_SAMPLE = 2'b00,
		SLTPG_PT_SYMBOL = 2'b01,
		SLTPG_PT_OCTET = 2'b10,
		SLTPG_PT_RSVD = 2'b11
	} sltpg_point_t;
	// Word handed to the link datapath
	typedef struct packed {
		logic active;
		sltpg_point_t point;
		logic [15:0] data;
	} sltpg_out_t;
endpackage

/* File: test/sltpg_rx.sv */
// Purpose: Link receiver stand-in that takes one word per pattern slot
// Assumes: The word settles in the cycle after a slot strobe
// Notes: o_word is meaningful only while o_got is high
`timescale 1ns/1ps
module sltpg_rx (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_step,
	input sltpg_pkg::sltpg_out_t i_tp,
	output logic o_got,
	output logic [15:0] o_word
);
	import sltpg_pkg::*;
	// One received word per frame slot
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			o_got <= 1'b0;
		else
			o_got <= i_step;
	end
	// Word as seen on the datapath
	assign o_word = i_tp.data;
endmodule

/* File: test/sltpg_top_tb.sv */
// Purpose: Self-checking bench for the test pattern generator
// Assumes: Inputs change at the falling edge of the clock
// Notes: Expected words queue up; a monitor pops one per received word
`timescale 1ns/1ps
`include "sltpg_cfg.svh"
module sltpg_top_tb;
	import sltpg_pkg::*;
	logic clk = 0, rst = 1, wr = 0, rd = 0, stp = 0, got, ex;
	logic [11:0] ad = 0;
	logic [7:0] wd = 0, rdat;
	logic [15:0] nd = 0, word;
	logic [15:0] up [4];
	logic [15:0] q [$];
	logic [31:0] rs = 32'hD524;
	sltpg_out_t tp;
	int failures = 0, tests_run = 0, cyc = 0;
	// Clock, 40 ns period
	always #20 clk = ~clk;
	sltpg_top sltpg_top_i (.i_core_clk(clk), .i_rst(rst), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_addr(ad), .i_reg_wdata(wd),
		.o_reg_rdata(rdat), .i_step(stp), .i_norm_data(nd), .o_tp(tp));
	sltpg_rx sltpg_rx_i (.i_core_clk(clk), .i_rst(rst), .i_step(stp),
		.i_tp(tp), .o_got(got), .o_word(word));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input string n, input logic [15:0] e, g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wreg(input logic [11:0] a, input logic [7:0] d);
		wr = 1;
		ad = a;
		wd = d;
		@(negedge clk) wr = 0;
		@(negedge clk);
	endtask
	task automatic rreg(input logic [11:0] a, input logic [7:0] e);
		rd = 1;
		ad = a;
		@(negedge clk) rd = 0;
		chk("rdata", {8'h00, e}, {8'h00, rdat});
		@(negedge clk);
	endtask
	// Select a pattern, then step once per cycle, noting each word
	task automatic run(input logic [7:0] c, input logic [15:0] e [$]);
		wreg(`SLTPG_ADDR_CTRL, c);
		chk("point", {14'h0000, c[5:4]}, {14'h0000, tp.point});
		foreach (e[i]) begin
			q.push_back(e[i]);
			stp = 1;
			@(negedge clk);
		end
		stp = 0;
		repeat (2) @(negedge clk);
		$display("test ctrl %h done", c);
	endtask
	// Monitor: compare each received word with the oldest note
	always @(negedge clk) begin
		if (got === 1'b1) begin
			if (q.size() == 0)
				chk("extra word", 16'h0000, 16'hFFFF);
			else
				chk("word", q.pop_front(), word);
		end
	end
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		repeat (3) @(negedge clk);
		rst = 0;
		rreg(`SLTPG_ADDR_CTRL, `SLTPG_CTRL_RST);
		rreg(12'h7FF, 8'h00);
		for (int c = 0; c < 16; c++) begin
			wreg(`SLTPG_ADDR_CTRL, 8'(c));
			@(negedge clk);
			ex = !(c == 0 || (c > 8 && c < 14));
			chk("active", {15'h0, ex}, {15'h0, tp.active});
		end
		$display("test code sweep done");
		run(8'h06, '{16'h496F, 16'hC9A9, 16'h980C, 16'h651A});
		run(8'h04, '{16'hFF5C, 16'h0029, 16'hB80A, 16'h3D72});
		run(8'h03, '{16'hFFF5});
		run(8'h05, '{16'hF5C0});
		run(8'h07, '{16'hE041});
		run(8'h01, '{16'h5555, 16'hAAAA, 16'h5555});
		run(8'h02, '{16'h0000, 16'hFFFF, 16'h0000});
		run(8'h08, '{16'h0000, 16'h0001, 16'h0002});
		run(8'h16, '{16'h0125, 16'h02FC});
		run(8'h26, '{16'h0049, 16'h006F});
		run(8'h12, '{16'h0000, 16'h03FF});
		for (int i = 0; i < 4; i++) begin
			rs = xs(rs);
			up[i] = rs[15:0];
			wreg(12'h551 + 12'(2 * i), up[i][7:0]);
			wreg(12'h552 + 12'(2 * i), up[i][15:8]);
		end
		rreg(12'h558, up[3][15:8]);
		run(8'h0E, '{up[0], up[1], up[2], up[3], up[0]});
		run(8'h0F, '{up[0], up[1], up[2], up[3], 16'h0, 16'h0});
		run(8'h2E, '{16'(up[0][15:8]), 16'(up[1][15:8])});
		wreg(`SLTPG_ADDR_SOFT_RST, `SLTPG_SOFT_RST_VAL);
		rreg(`SLTPG_ADDR_CTRL, 8'h00);
		rs = xs(rs);
		nd = rs[15:0];
		@(negedge clk);
		chk("pass", nd, tp.data);
		chk("queue", 16'h0000, 16'(q.size()));
		$display("test soft reset done");
		close_out();
	end
endmodule
